/* File: lof_mon_pkg.sv */
// constants, register map and state layout of the loss-of-frame monitor
package lof_mon_pkg;

  // clock and declaration time
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned LOF_SET_TIME_MS = 3;
  localparam int unsigned LOF_SET_CYCLES  = (CLK_HZ / 1000) * LOF_SET_TIME_MS;
  localparam int unsigned TIMER_W         = 17;

  // frames of good alignment that end the severe framing error state
  localparam logic [1:0] SEF_CLEAR_FRAMES = 2'h2;

  // register indices; the byte address is four times the index
  localparam logic [15:0] STATUS_IDX  = 16'h1107;
  localparam logic [15:0] EVENT_IDX   = 16'h110B;
  localparam logic [15:0] LIMIT_IDX   = 16'h112B;
  localparam logic [15:0] STATUS_ADDR = {STATUS_IDX[13:0], 2'h0};
  localparam logic [15:0] EVENT_ADDR  = {EVENT_IDX[13:0], 2'h0};
  localparam logic [15:0] LIMIT_ADDR  = {LIMIT_IDX[13:0], 2'h0};

  // field positions
  localparam int unsigned SEF_BIT      = 1;
  localparam int unsigned LOF_BIT      = 2;
  localparam int unsigned LIMIT_LSB    = 0;
  localparam int unsigned EXIT_SEL_LSB = 4;

  // reset values
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] EVENT_RST  = 8'h00;
  localparam logic [7:0] LIMIT_RST  = 8'h00;

  // register decode result
  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_STATUS = 2'b01,
    SEL_EVENT  = 2'b10,
    SEL_LIMIT  = 2'b11
  } reg_sel_e;

  typedef struct packed {
    logic               severe_frame_error_defect;
    logic [1:0]         sef_good;
    logic               lof;
    logic [TIMER_W-1:0] lof_timer;
    logic [3:0]         good_run;
    logic [3:0]         limit;
    logic [1:0]         exit_sel;
    logic [7:0]         flags;
    logic [31:0]        rdata;
  } mon_state_s;

endpackage

/* File: sts3_lof_defect_monitor.sv */
// loss-of-frame declaration and clearance with status, event flags and apb access
// Overview of operation
// R1: loss of frame declared once severe framing error held three milliseconds
// R2: loss of frame declaration sets status register bit 2
// R3: every loss-of-frame change sets event bit 2 and pulls interrupt low
// R4: loss of frame clears only after sef cleared and threshold good frames
// R5: software writes the good-frame threshold into limit register bits 3..0
// R6: good-frame counting toward threshold starts only once sef has cleared
// R7: loss-of-frame clearance resets status bit 2 and raises the change event
// R8: sef clears after two consecutive frames with error-free alignment bytes
// R9: errored frame or renewed sef restarts the clearance count at zero
`timescale 1ns/1ps
module sts3_lof_defect_monitor #(
  parameter int unsigned LOF_SET_CYCLES = lof_mon_pkg::LOF_SET_CYCLES
) (
  input  wire logic        MCLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        FRAME_DONE_I,
  input  wire logic        FRAME_ALIGN_OK_I,
  input  wire logic        SEF_DECLARE_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [15:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  input  wire logic [3:0]  PSTRB_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             SEF_O,
  output logic             LOF_O,
  output logic             INT_N_O
);

  localparam logic [lof_mon_pkg::TIMER_W-1:0] TIMER_LAST =
    lof_mon_pkg::TIMER_W'(LOF_SET_CYCLES - 1);

  lof_mon_pkg::mon_state_s st;
  lof_mon_pkg::mon_state_s next_st;

  logic                  access;
  logic                  setup;
  lof_mon_pkg::reg_sel_e sel;

  function automatic lof_mon_pkg::reg_sel_e reg_sel(input logic [15:0] addr);
    unique case (addr)
      lof_mon_pkg::STATUS_ADDR: reg_sel = lof_mon_pkg::SEL_STATUS;
      lof_mon_pkg::EVENT_ADDR:  reg_sel = lof_mon_pkg::SEL_EVENT;
      lof_mon_pkg::LIMIT_ADDR:  reg_sel = lof_mon_pkg::SEL_LIMIT;
      default:                  reg_sel = lof_mon_pkg::SEL_NONE;
    endcase
  endfunction

  function automatic logic [7:0] status_byte(input logic severe_frame_error_defect, input logic lof);
    status_byte = lof_mon_pkg::STATUS_RST;
    status_byte[lof_mon_pkg::SEF_BIT] = severe_frame_error_defect;
    status_byte[lof_mon_pkg::LOF_BIT] = lof; // R2 R7
  endfunction

  assign access = PSEL_I && PENABLE_I;
  assign setup  = PSEL_I && !PENABLE_I;
  assign sel    = reg_sel(PADDR_I);

  always_comb begin
    next_st = st;

    // severe framing error: declared from outside, cleared by good frames
    if (SEF_DECLARE_I) begin
      next_st.severe_frame_error_defect      = 1'b1;
      next_st.sef_good = 2'h0;
    end else if (st.severe_frame_error_defect && FRAME_DONE_I) begin
      if (!FRAME_ALIGN_OK_I) begin
        next_st.sef_good = 2'h0;
      end else if (st.sef_good == lof_mon_pkg::SEF_CLEAR_FRAMES - 2'h1) begin
        next_st.severe_frame_error_defect      = 1'b0; // R8
        next_st.sef_good = 2'h0;
      end else begin
        next_st.sef_good = st.sef_good + 2'h1;
      end
    end

    // declaration timer runs only while sef stands and lof is absent
    if (!st.severe_frame_error_defect || st.lof) begin
      next_st.lof_timer = '0;
    end else if (st.lof_timer == TIMER_LAST) begin
      next_st.lof       = 1'b1; // R1 R2
      next_st.lof_timer = '0;
    end else begin
      next_st.lof_timer = st.lof_timer + 1'b1;
    end

    // clearance: count consecutive good frames after sef has gone
    if (!st.lof || st.severe_frame_error_defect) begin
      next_st.good_run = 4'h0; // R6 R9
    end else if (st.good_run >= st.limit) begin
      next_st.lof      = 1'b0; // R4 R7
      next_st.good_run = 4'h0;
    end else if (FRAME_DONE_I) begin
      if (FRAME_ALIGN_OK_I) begin
        next_st.good_run = st.good_run + 4'h1;
      end else begin
        next_st.good_run = 4'h0; // R9
      end
    end

    // read of the event register clears only the bits it reported
    if (access && !PWRITE_I && sel == lof_mon_pkg::SEL_EVENT) begin
      next_st.flags = st.flags & ~st.rdata[7:0];
    end
    // a change in the same cycle as the clear still sets its flag
    next_st.flags[lof_mon_pkg::SEF_BIT] = next_st.flags[lof_mon_pkg::SEF_BIT] |
                                          (next_st.severe_frame_error_defect ^ st.severe_frame_error_defect);
    next_st.flags[lof_mon_pkg::LOF_BIT] = next_st.flags[lof_mon_pkg::LOF_BIT] |
                                          (next_st.lof ^ st.lof); // R3 R7

    // threshold and pattern select writes
    if (access && PWRITE_I && sel == lof_mon_pkg::SEL_LIMIT && PSTRB_I[0]) begin
      next_st.limit    = PWDATA_I[lof_mon_pkg::LIMIT_LSB +: 4]; // R5
      next_st.exit_sel = PWDATA_I[lof_mon_pkg::EXIT_SEL_LSB +: 2];
    end

    // read data is captured in the setup cycle and stands through the access
    if (setup) begin
      next_st.rdata = 32'h0;
      if (!PWRITE_I) begin
        unique case (sel)
          lof_mon_pkg::SEL_STATUS: next_st.rdata[7:0] = status_byte(st.severe_frame_error_defect, st.lof);
          lof_mon_pkg::SEL_EVENT:  next_st.rdata[7:0] = st.flags;
          lof_mon_pkg::SEL_LIMIT: begin
            next_st.rdata[lof_mon_pkg::LIMIT_LSB +: 4]    = st.limit;
            next_st.rdata[lof_mon_pkg::EXIT_SEL_LSB +: 2] = st.exit_sel;
          end
          lof_mon_pkg::SEL_NONE:   next_st.rdata = 32'h0;
        endcase
      end
    end

    if (!RSTN_I) begin
      next_st          = '0;
      next_st.severe_frame_error_defect      = lof_mon_pkg::STATUS_RST[lof_mon_pkg::SEF_BIT];
      next_st.lof      = lof_mon_pkg::STATUS_RST[lof_mon_pkg::LOF_BIT];
      next_st.flags    = lof_mon_pkg::EVENT_RST;
      next_st.limit    = lof_mon_pkg::LIMIT_RST[lof_mon_pkg::LIMIT_LSB +: 4];
      next_st.exit_sel = lof_mon_pkg::LIMIT_RST[lof_mon_pkg::EXIT_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge MCLK_I) begin
    st <= next_st;
  end

  assign PRDATA_O  = st.rdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = access && sel == lof_mon_pkg::SEL_NONE;
  assign SEF_O     = st.severe_frame_error_defect;
  assign LOF_O     = st.lof;
  assign INT_N_O   = ~(|st.flags); // R3

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);

  sequence sef_last_good_s;
    st.severe_frame_error_defect && !SEF_DECLARE_I && FRAME_DONE_I && FRAME_ALIGN_OK_I &&
      st.sef_good == 2'h1;
  endsequence

  sequence status_read_s;
    PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == lof_mon_pkg::STATUS_ADDR;
  endsequence

  sequence event_read_s;
    access && !PWRITE_I && PADDR_I == lof_mon_pkg::EVENT_ADDR;
  endsequence

  sequence clear_ready_s;
    st.lof && !st.severe_frame_error_defect && st.good_run >= st.limit;
  endsequence

  sequence errored_frame_s;
    st.lof && !st.severe_frame_error_defect && st.good_run < st.limit && FRAME_DONE_I && !FRAME_ALIGN_OK_I;
  endsequence

  lof_declare_a: assert property ( // R1
    $rose(st.lof) |-> $past(st.severe_frame_error_defect) && $past(st.lof_timer) == TIMER_LAST)
    else $error("loss of frame declared before sef was held long enough");

  lof_early_a: assert property ( // R1
    !st.severe_frame_error_defect && !st.lof |=> !st.lof)
    else $error("loss of frame declared without sef");

  status_bit_a: assert property ( // R2
    status_read_s |=> PRDATA_O[lof_mon_pkg::LOF_BIT] == $past(st.lof) && PREADY_O)
    else $error("status read does not show loss of frame");

  lof_event_a: assert property ( // R3
    $changed(st.lof) |-> st.flags[lof_mon_pkg::LOF_BIT] && !INT_N_O)
    else $error("loss of frame change did not raise the event");

  // without a read of the event register a set flag must survive the next edge
  event_hold_a: assert property ( // R3
    st.flags[lof_mon_pkg::LOF_BIT] &&
      !(access && !PWRITE_I && sel == lof_mon_pkg::SEL_EVENT) |=>
      st.flags[lof_mon_pkg::LOF_BIT])
    else $error("event flag lost without a read");

  // a flag set after the read data was captured is not cleared by that read
  event_clear_a: assert property ( // R3
    event_read_s ##0 (!st.rdata[lof_mon_pkg::LOF_BIT] && st.flags[lof_mon_pkg::LOF_BIT])
      |=> st.flags[lof_mon_pkg::LOF_BIT])
    else $error("unreported event flag cleared by a read");

  int_flag_a: assert property ( // R3
    st.flags[lof_mon_pkg::LOF_BIT] |-> !INT_N_O)
    else $error("interrupt not active while loss of frame event stands");

  lof_rise_a: assert property ( // R2
    $rose(st.lof) |-> LOF_O && st.flags[lof_mon_pkg::LOF_BIT] && !INT_N_O)
    else $error("loss of frame declaration not reported");

  status_clear_a: assert property ( // R7
    $fell(st.lof) |-> !LOF_O && st.flags[lof_mon_pkg::LOF_BIT])
    else $error("loss of frame clearance not reported");

  // the declaration timer only runs while sef stands
  timer_idle_a: assert property ( // R1
    !st.severe_frame_error_defect |=> st.lof_timer == '0)
    else $error("declaration timer runs without sef");

  timer_step_a: assert property ( // R1
    st.severe_frame_error_defect && !st.lof && st.lof_timer != TIMER_LAST |=>
      st.lof_timer == $past(st.lof_timer) + 1'b1)
    else $error("declaration timer did not advance");

  lof_stay_low_a: assert property ( // R1
    !st.lof && !(st.severe_frame_error_defect && st.lof_timer == TIMER_LAST) |=> !st.lof)
    else $error("loss of frame declared before the timer expired");

  count_step_a: assert property ( // R4
    st.lof && !st.severe_frame_error_defect && st.good_run < st.limit && FRAME_DONE_I && FRAME_ALIGN_OK_I |=>
      st.good_run == $past(st.good_run) + 4'h1)
    else $error("good frame not counted toward clearance");

  good_hold_a: assert property ( // R4
    st.lof && !st.severe_frame_error_defect && st.good_run < st.limit && !FRAME_DONE_I |=>
      st.good_run == $past(st.good_run))
    else $error("clearance count moved without a frame");

  sef_restart_a: assert property ( // R9
    SEF_DECLARE_I |=> st.severe_frame_error_defect ##1 st.good_run == 4'h0)
    else $error("renewed sef did not restart the clearance count");

  sef_good_reset_a: assert property ( // R8
    st.severe_frame_error_defect && FRAME_DONE_I && !FRAME_ALIGN_OK_I |=> st.severe_frame_error_defect && st.sef_good == 2'h0)
    else $error("errored frame did not restart the sef clear count");

  // the threshold only changes through a byte-enabled write of its register
  limit_write_a: assert property ( // R5
    access && PWRITE_I && sel == lof_mon_pkg::SEL_LIMIT && PSTRB_I[0] |=>
      st.limit == $past(PWDATA_I[lof_mon_pkg::LIMIT_LSB +: 4]))
    else $error("threshold write not taken");

  limit_keep_a: assert property ( // R5
    !(access && PWRITE_I && sel == lof_mon_pkg::SEL_LIMIT) |=> $stable(st.limit))
    else $error("threshold changed without a write");

  lof_hold_a: assert property ( // R4
    st.lof && st.severe_frame_error_defect |=> st.lof)
    else $error("loss of frame cleared while sef stands");

  lof_clear_a: assert property ( // R4 R7
    clear_ready_s |=> !st.lof ##0 st.flags[lof_mon_pkg::LOF_BIT] && !INT_N_O)
    else $error("loss of frame not cleared at threshold");

  lof_fell_a: assert property ( // R7
    $fell(st.lof) |-> $past(!st.severe_frame_error_defect) && $past(st.good_run) >= $past(st.limit))
    else $error("loss of frame cleared early");

  count_gate_a: assert property ( // R6
    st.severe_frame_error_defect |=> st.good_run == 4'h0)
    else $error("clearance count runs while sef stands");

  count_restart_a: assert property ( // R9
    errored_frame_s |=> st.good_run == 4'h0 && st.lof)
    else $error("errored frame did not restart the clearance count");

  sef_clear_a: assert property ( // R8
    sef_last_good_s |=> !st.severe_frame_error_defect ##0 st.flags[lof_mon_pkg::SEF_BIT])
    else $error("sef not cleared after two good frames");

  sef_stay_a: assert property ( // R8
    st.severe_frame_error_defect && st.sef_good == 2'h0 && !(FRAME_DONE_I && FRAME_ALIGN_OK_I) |=> st.severe_frame_error_defect)
    else $error("sef cleared without two good frames");

endmodule

/* File: frame_src.sv */
// far-end frame source model: frame ends, alignment result, severe framing error
`timescale 1ns/1ps
module frame_src (
  input  wire logic clk_i,
  output logic      done_o,
  output logic      ok_o,
  output logic      sef_o
);
  initial begin
    done_o = 1'b0;
    ok_o   = 1'b0;
    sef_o  = 1'b0;
  end
  task automatic frames(input int n, input logic good, input int gap);
    repeat (n) begin
      @(posedge clk_i);
      done_o <= 1'b1;
      ok_o   <= good;
      @(posedge clk_i);
      done_o <= 1'b0;
      // between frames the flag carries no meaning, so it shows the opposite
      ok_o   <= ~good;
      repeat (gap) @(posedge clk_i);
    end
  endtask
  task automatic declare();
    @(posedge clk_i);
    sef_o <= 1'b1;
    @(posedge clk_i);
    sef_o <= 1'b0;
  endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the loss-of-frame monitor
`timescale 1ns/1ps
module testbench;
  localparam int unsigned N = 20;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        severe_frame_error_defect;
  logic        lof;
  logic        int_n;
  logic        done;
  logic        ok;
  logic        sef_in;
  logic [32:0] q[$];
  logic [32:0] exp_v;
  logic [31:0] seed = 32'h79F7A737;
  int          fail_count = 0;
  int          n_tests = 0;
  always #12.5 mclk = ~mclk;
  sts3_lof_defect_monitor #(.LOF_SET_CYCLES(N)) sts3_lof_defect_monitor_inst (
    .MCLK_I(mclk), .RSTN_I(rstn), .FRAME_DONE_I(done), .FRAME_ALIGN_OK_I(ok),
    .SEF_DECLARE_I(sef_in), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SEF_O(severe_frame_error_defect), .LOF_O(lof), .INT_N_O(int_n));
  frame_src frame_src_inst (.clk_i(mclk), .done_o(done), .ok_o(ok), .sef_o(sef_in));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] want);
    n_tests++;
    if (got !== want) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // one apb transfer; a read leaves its expected {slverr, data} in the queue
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    if (!w) q.push_back(e);
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  always @(posedge mclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
      exp_v = q.pop_front();
      chk({pslverr, prdata}, exp_v);
    end
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    apb(0, lof_mon_pkg::STATUS_ADDR, 0, 33'h000000000);
    apb(0, lof_mon_pkg::EVENT_ADDR, 0, 33'h000000000);
    apb(0, lof_mon_pkg::LIMIT_ADDR, 0, 33'h000000000);
    apb(0, 16'h0F00, 0, 33'h100000000);
    apb(1, lof_mon_pkg::LIMIT_ADDR, (xs() & 32'hFFFFFFC0) | 32'h00000035, 0);
    apb(0, lof_mon_pkg::LIMIT_ADDR, 0, 33'h000000035);
    apb(1, lof_mon_pkg::STATUS_ADDR, 32'hFF, 0);
    // short severe error episode must not raise loss of frame
    frame_src_inst.declare();
    frame_src_inst.frames(2, 1'b1, xs() % 3 + 1);
    repeat (N) @(posedge mclk);
    chk(int_n, 1'b0);
    apb(0, lof_mon_pkg::STATUS_ADDR, 0, 33'h000000000);
    apb(0, lof_mon_pkg::EVENT_ADDR, 0, 33'h000000002);
    apb(0, lof_mon_pkg::EVENT_ADDR, 0, 33'h000000000);
    @(negedge mclk);
    chk(int_n, 1'b1);
    frame_src_inst.declare();
    repeat (N + 3) @(posedge mclk);
    apb(0, lof_mon_pkg::STATUS_ADDR, 0, 33'h000000006);
    chk({severe_frame_error_defect, lof}, 2'b11);
    apb(0, lof_mon_pkg::EVENT_ADDR, 0, 33'h000000006);
    frame_src_inst.frames(2, 1'b1, xs() % 3 + 1);
    frame_src_inst.frames(4, 1'b1, xs() % 3 + 1);
    frame_src_inst.frames(1, 1'b0, 1);
    frame_src_inst.frames(4, 1'b1, xs() % 3 + 1);
    apb(0, lof_mon_pkg::STATUS_ADDR, 0, 33'h000000004);
    frame_src_inst.frames(1, 1'b1, 2);
    apb(0, lof_mon_pkg::STATUS_ADDR, 0, 33'h000000000);
    chk({severe_frame_error_defect, lof}, 2'b00);
    chk(int_n, 1'b0);
    apb(0, lof_mon_pkg::EVENT_ADDR, 0, 33'h000000006);
    // reset in mid-run while both defects stand
    frame_src_inst.declare();
    repeat (N + 3) @(posedge mclk);
    @(negedge mclk);
    chk({severe_frame_error_defect, lof}, 2'b11);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    chk({severe_frame_error_defect, lof, int_n}, 3'b001);
    apb(0, lof_mon_pkg::STATUS_ADDR, 0, 33'h000000000);
    apb(0, lof_mon_pkg::LIMIT_ADDR, 0, 33'h000000000);
    repeat (2) @(posedge mclk);
    give_verdict();
  end
endmodule
